// ==== ies_intr_seq.sv ====
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - fetch interrupt id into temp; fault gives stack exception, id-fetch
// - force kernel after id capture; quick path when quick enable is 1
// - full interrupt: temp becomes 140 plus 4 times the id
// - push old block pointer on interrupt stack; fault is reset class
// - save old context with fields 0,0,1; fault is process old-block
// - load new pointer, status, pc, sp; clear initial flag, adjust pointer
// - after load, live status gets fields 7,0,3
// - full path performs map block moves; fault is process new-block
// - full path ends by releasing forced kernel
// - quick interrupt: temp becomes 1164 plus 8 times the id
// - quick: release kernel, push status and pc, force kernel again
// - quick: load status and pc+4, priority 15; fault is gate-vector
// - quick path ends by releasing forced kernel
// - handler only takes a level above its loaded priority level
// - return-to-process pops pointer, restores context, does map moves
// - return-to-process saves nothing of the exiting handler
// - return-from-gate pops status and pc off the execution stack
// - four severity levels, 0 most severe; type and state code
// - ordinary execution holds type 3 and state code 7
// - exceptions keep type and state code for the handler
// - type 0 reset, 1 process, 2 stack
// - memory errors arrive on a fault input
// - type 3 is the normal, least severe class
// - maskable interrupt taken only when level exceeds priority level
module ies_intr_seq
   import ies_pkg::*;
(
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input logic int_nmi,
   input logic [3:0] int_level,
   output logic mem_req,
   output logic mem_we,
   output logic mem_iack,
   output logic mem_kernel,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input logic mem_ack,
   input logic [31:0] mem_rdata,
   input logic mem_fault
);
   ////////////////////////////////////////////////////////////////////////
   ies_mem_if mi ();
   logic [4:0] pins_s;
   logic nmi_d_r, nmi_pend_r, nmi_pend_nxt, nmi_take_r, nmi_take_nxt;
   logic [31:0] psw_r, psw_nxt, pc_r, pc_nxt, sp_r, sp_nxt;
   logic [31:0] process_block_pointer_r, process_block_pointer_nxt, isp_r, isp_nxt, temp_r, temp_nxt;
   logic [31:0] map_r, map_nxt;
   ies_state_t st_r, st_nxt;
   logic [1:0] sub_r, sub_nxt;
   logic busy_r, busy_nxt, kern_r, kern_nxt, ret_r, ret_nxt;
   logic exc_r, exc_nxt;
   logic [1:0] exc_et_r, exc_et_nxt;
   logic [3:0] exc_isc_r, exc_isc_nxt;
   logic acc_c, we_c, iack_c;
   logic [31:0] addr_c, wdata_c;

   ies_sync2 #(.W(5)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({int_nmi, int_level}),
      .q(pins_s)
   );

   ies_mem_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .mi(mi.port),
      .mem_req(mem_req),
      .mem_we(mem_we),
      .mem_iack(mem_iack),
      .mem_kernel(mem_kernel),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata),
      .mem_fault(mem_fault)
   );

   ////////////////////////////////////////////////////////////////////////
   // apb slave
   wire [3:0] lvl_s = pins_s[3:0];
   wire nmi_s = pins_s[4];
   wire [3:0] priority_level_field = psw_r[IPL_LSB +: 4];
   wire idle = (st_r == ST_IDLE);
   wire acc_ph = psel && penable && !pready;
   wire wr = psel && penable && pready && pwrite;
   wire hit = (paddr == REG_PSW) || (paddr == REG_PC) ||
      (paddr == REG_SP) || (paddr == REG_PROCESS_BLOCK_POINTER) || (paddr == REG_ISP) ||
      (paddr == REG_TEMP) || (paddr == REG_STAT) || (paddr == REG_CMD) ||
      (paddr == REG_MAPW);
   wire [31:0] stat = {15'h0, kern_r, 4'h0, exc_isc_r, 2'h0, exc_et_r,
      2'h0, exc_r, !idle};
   wire [31:0] rd =
      (paddr == REG_PSW) ? psw_r :
      (paddr == REG_PC) ? pc_r :
      (paddr == REG_SP) ? sp_r :
      (paddr == REG_PROCESS_BLOCK_POINTER) ? process_block_pointer_r :
      (paddr == REG_ISP) ? isp_r :
      (paddr == REG_TEMP) ? temp_r :
      (paddr == REG_STAT) ? stat :
      (paddr == REG_MAPW) ? map_r : 32'h0;
   // context registers are only writable while the sequencer rests
   wire cpu_wr = wr && idle;
   wire cmd_return_to_process_op = cpu_wr && (paddr == REG_CMD) && pwdata[0];
   wire cmd_return_from_gate_op = cpu_wr && (paddr == REG_CMD) && pwdata[1];
   wire exc_clr = wr && (paddr == REG_STAT) && pwdata[1];

   ////////////////////////////////////////////////////////////////////////
   // interrupt acceptance
   wire nmi_edge = nmi_s && !nmi_d_r;
   wire lvl_ok = (lvl_s > priority_level_field);
   wire take = idle && !busy_r && !exc_r && (nmi_pend_r || lvl_ok);
   wire [7:0] id = temp_r[7:0];
   wire [31:0] ctx_ofs = {28'h0, sub_r, 2'b00};
   wire [31:0] quick_psw = {ies_psw_mark(mi.rdata, psw_r[ISC_LSB +: 4],
      psw_r[TM_BIT], psw_r[ET_LSB +: 2])};
   wire ok = mi.done && !mi.fault;

   assign mi.start = acc_c && !busy_r;
   assign mi.we = we_c;
   assign mi.iack = iack_c;
   assign mi.addr = addr_c;
   assign mi.wdata = wdata_c;
   assign mi.kernel = kern_r;

   always_comb begin
      psw_nxt = psw_r;
      pc_nxt = pc_r;
      sp_nxt = sp_r;
      process_block_pointer_nxt = process_block_pointer_r;
      isp_nxt = isp_r;
      temp_nxt = temp_r;
      map_nxt = map_r;
      st_nxt = st_r;
      sub_nxt = sub_r;
      kern_nxt = kern_r;
      ret_nxt = ret_r;
      nmi_take_nxt = nmi_take_r;
      exc_nxt = exc_r && !exc_clr;
      exc_et_nxt = exc_et_r;
      exc_isc_nxt = exc_isc_r;
      acc_c = 1'b0;
      we_c = 1'b0;
      iack_c = 1'b0;
      addr_c = 32'h0;
      wdata_c = 32'h0;
      if (cpu_wr) begin
         if (paddr == REG_PSW) psw_nxt = pwdata;
         else if (paddr == REG_PC) pc_nxt = pwdata;
         else if (paddr == REG_SP) sp_nxt = pwdata;
         else if (paddr == REG_PROCESS_BLOCK_POINTER) process_block_pointer_nxt = pwdata;
         else if (paddr == REG_ISP) isp_nxt = pwdata;
      end
      case (st_r)
         ST_IDLE: begin
            if (take) begin
               nmi_take_nxt = nmi_pend_r;
               st_nxt = ST_IDF;
            end else if (cmd_return_to_process_op) begin
               ret_nxt = 1'b1;
               st_nxt = ST_RPOP;
            end else if (cmd_return_from_gate_op) begin
               st_nxt = ST_RGPOP;
            end
         end
         ST_IDF: begin
            acc_c = 1'b1;
            iack_c = 1'b1;
            addr_c = {28'h0, lvl_s};
            if (ok) begin
               // nonmaskable entry always uses id zero
               temp_nxt = nmi_take_r ? 32'h0 : {24'h0, mi.rdata[7:0]};
               kern_nxt = 1'b1;
               st_nxt = ST_IDX;
            end
         end
         ST_IDX: begin
            sub_nxt = 2'h0;
            if (psw_r[QIE_BIT]) begin
               temp_nxt = ies_vec_addr(QUICK_BASE, id, QUICK_SHIFT);
               kern_nxt = 1'b0;
               st_nxt = ST_QPUSH;
            end else begin
               temp_nxt = ies_vec_addr(FULL_BASE, id, FULL_SHIFT);
               st_nxt = ST_PUSH;
            end
         end
         ST_PUSH: begin
            acc_c = 1'b1;
            we_c = 1'b1;
            addr_c = isp_r;
            wdata_c = process_block_pointer_r;
            if (ok) begin
               isp_nxt = isp_r + WORD;
               st_nxt = ST_SAVE;
            end
         end
         ST_SAVE: begin
            acc_c = 1'b1;
            we_c = 1'b1;
            addr_c = process_block_pointer_r + ctx_ofs;
            if (sub_r == 2'h0)
               wdata_c = ies_psw_mark(psw_r, ISC_SAVED, 1'b0, ET_SAVED);
            else if (sub_r == 2'h1)
               wdata_c = pc_r;
            else
               wdata_c = sp_r;
            if (ok) begin
               sub_nxt = (sub_r == 2'h2) ? 2'h0 : sub_r + 2'h1;
               if (sub_r == 2'h2) st_nxt = ST_LOAD;
            end
         end
         ST_LOAD: begin
            acc_c = 1'b1;
            addr_c = (sub_r == 2'h0) ? temp_r : process_block_pointer_r + ctx_ofs - WORD;
            if (ok) begin
               sub_nxt = sub_r + 2'h1;
               if (sub_r == 2'h0) process_block_pointer_nxt = mi.rdata;
               else if (sub_r == 2'h1) psw_nxt = mi.rdata;
               else if (sub_r == 2'h2) pc_nxt = mi.rdata;
               else begin
                  sp_nxt = mi.rdata;
                  sub_nxt = 2'h0;
                  st_nxt = ST_MAP;
                  if (!ret_r) begin
                     // the context loaded above was the handler's initial one
                     psw_nxt = ies_psw_mark(psw_r, ISC_RUN, 1'b0, ET_NORMAL);
                     if (psw_r[I_BIT]) begin
                        psw_nxt[I_BIT] = 1'b0;
                        process_block_pointer_nxt = process_block_pointer_r + SAVE_AREA_OFS;
                     end
                  end
               end
            end
         end
         ST_MAP: begin
            acc_c = psw_r[R_BIT];
            addr_c = process_block_pointer_r + MAP_OFS;
            if (ok || !psw_r[R_BIT]) begin
               if (psw_r[R_BIT]) map_nxt = mi.rdata;
               kern_nxt = 1'b0;
               ret_nxt = 1'b0;
               st_nxt = ST_IDLE;
            end
         end
         ST_QPUSH: begin
            acc_c = 1'b1;
            we_c = 1'b1;
            addr_c = sp_r + ctx_ofs;
            wdata_c = (sub_r == 2'h0) ? psw_r : pc_r;
            if (ok) begin
               sub_nxt = (sub_r == 2'h1) ? 2'h0 : 2'h1;
               if (sub_r == 2'h1) begin
                  sp_nxt = sp_r + PAIR;
                  kern_nxt = 1'b1;
                  st_nxt = ST_QVEC;
               end
            end
         end
         ST_QVEC: begin
            acc_c = 1'b1;
            addr_c = temp_r + ctx_ofs;
            if (ok) begin
               sub_nxt = (sub_r == 2'h1) ? 2'h0 : 2'h1;
               if (sub_r == 2'h0) begin
                  psw_nxt = quick_psw;
                  psw_nxt[IPL_LSB +: 4] = IPL_ALL;
               end else begin
                  pc_nxt = mi.rdata;
                  kern_nxt = 1'b0;
                  st_nxt = ST_IDLE;
               end
            end
         end
         ST_RPOP: begin
            // nothing of the exiting handler is written back
            acc_c = 1'b1;
            addr_c = isp_r - WORD;
            if (ok) begin
               isp_nxt = isp_r - WORD;
               process_block_pointer_nxt = mi.rdata;
               sub_nxt = 2'h1;
               st_nxt = ST_LOAD;
            end
         end
         ST_RGPOP: begin
            acc_c = 1'b1;
            addr_c = sp_r - PAIR + ctx_ofs;
            if (ok) begin
               sub_nxt = (sub_r == 2'h1) ? 2'h0 : 2'h1;
               if (sub_r == 2'h0) psw_nxt = mi.rdata;
               else begin
                  pc_nxt = mi.rdata;
                  sp_nxt = sp_r - PAIR;
                  st_nxt = ST_IDLE;
               end
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      // a fault aborts the step and is reported by class and state code
      if (mi.done && mi.fault) begin
         exc_nxt = 1'b1;
         st_nxt = ST_IDLE;
         sub_nxt = 2'h0;
         kern_nxt = 1'b0;
         ret_nxt = 1'b0;
         exc_et_nxt = ET_PROC;
         exc_isc_nxt = ISC_NEW_PCB;
         if (st_r == ST_IDF) begin
            exc_et_nxt = ET_STACK;
            exc_isc_nxt = ISC_ID_FETCH;
         end else if (st_r == ST_PUSH) begin
            exc_et_nxt = ET_RESET;
            exc_isc_nxt = ISC_INT_STACK;
         end else if (st_r == ST_SAVE) begin
            exc_isc_nxt = ISC_OLD_PCB;
         end else if (st_r == ST_QVEC) begin
            exc_et_nxt = ET_NORMAL;
            exc_isc_nxt = ISC_GATE_VEC;
         end else if (st_r == ST_RGPOP || st_r == ST_QPUSH) begin
            exc_et_nxt = ET_NORMAL;
            exc_isc_nxt = ISC_EXT_MEM;
         end
      end
   end

   // edge set wins over the take that clears it
   assign nmi_pend_nxt = nmi_edge || (nmi_pend_r && !take);
   assign busy_nxt = mi.start || (busy_r && !mi.done);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psw_r <= PSW_RESET;
         pc_r <= ADDR_RESET;
         sp_r <= ADDR_RESET;
         process_block_pointer_r <= ADDR_RESET;
         isp_r <= ADDR_RESET;
         temp_r <= ADDR_RESET;
         map_r <= ADDR_RESET;
         st_r <= ST_IDLE;
         sub_r <= 2'h0;
         busy_r <= 1'b0;
         kern_r <= 1'b0;
         ret_r <= 1'b0;
         exc_r <= 1'b0;
         exc_et_r <= ET_NORMAL;
         exc_isc_r <= ISC_RUN;
         nmi_d_r <= 1'b0;
         nmi_pend_r <= 1'b0;
         nmi_take_r <= 1'b0;
      end else begin
         psw_r <= psw_nxt;
         pc_r <= pc_nxt;
         sp_r <= sp_nxt;
         process_block_pointer_r <= process_block_pointer_nxt;
         isp_r <= isp_nxt;
         temp_r <= temp_nxt;
         map_r <= map_nxt;
         st_r <= st_nxt;
         sub_r <= sub_nxt;
         busy_r <= busy_nxt;
         kern_r <= kern_nxt;
         ret_r <= ret_nxt;
         exc_r <= exc_nxt;
         exc_et_r <= exc_et_nxt;
         exc_isc_r <= exc_isc_nxt;
         nmi_d_r <= nmi_s;
         nmi_pend_r <= nmi_pend_nxt;
         nmi_take_r <= nmi_take_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= acc_ph;
         pslverr <= acc_ph && !hit;
         if (acc_ph) prdata <= rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_idfetch_fault_class: assert property (@(posedge pclk)
      disable iff (!presetn) (st_r == ST_IDF && mi.done && mi.fault)
      |=> (exc_r && exc_et_r == ET_STACK && exc_isc_r == ISC_ID_FETCH))
      else $error("id fetch fault not mapped to stack class");
   chk_kernel_forced: assert property (@(posedge pclk)
      disable iff (!presetn) (st_r == ST_IDX) |-> kern_r)
      else $error("kernel not forced after id capture");
   chk_full_index: assert property (@(posedge pclk)
      disable iff (!presetn) (st_r == ST_IDX && !psw_r[QIE_BIT])
      |=> (temp_r == 32'd140 + 32'd4 * {24'h0, $past(temp_r[7:0])}))
      else $error("full vector index wrong");
   chk_quick_index: assert property (@(posedge pclk)
      disable iff (!presetn) (st_r == ST_IDX && psw_r[QIE_BIT])
      |=> (temp_r == 32'd1164 + 32'd8 * {24'h0, $past(temp_r[7:0])})
      && !kern_r)
      else $error("quick vector index wrong");
   chk_push_fault_class: assert property (@(posedge pclk)
      disable iff (!presetn) (st_r == ST_PUSH && mi.done && mi.fault)
      |=> (exc_et_r == ET_RESET && st_r == ST_IDLE))
      else $error("interrupt stack fault not reset class");
   chk_saved_fields: assert property (@(posedge pclk)
      disable iff (!presetn) (mi.start && st_r == ST_SAVE && sub_r == 2'h0)
      |-> (mi.wdata[6:0] == 7'h01))
      else $error("saved status fields wrong");
   chk_handler_fields: assert property (@(posedge pclk)
      disable iff (!presetn)
      (st_r == ST_LOAD && sub_r == 2'h3 && ok && !ret_r)
      |=> (psw_r[6:0] == 7'h3b && st_r == ST_MAP))
      else $error("handler status fields wrong");
   chk_full_release: assert property (@(posedge pclk)
      disable iff (!presetn) (st_r == ST_MAP ##1 st_r == ST_IDLE)
      |-> !kern_r)
      else $error("kernel still forced after full entry");
   chk_quick_priority: assert property (@(posedge pclk)
      disable iff (!presetn) (st_r == ST_QVEC && sub_r == 2'h0 && ok)
      |=> (psw_r[IPL_LSB +: 4] == 4'hf))
      else $error("quick entry priority not raised");
   chk_mask_level: assert property (@(posedge pclk)
      disable iff (!presetn)
      (idle && !nmi_pend_r && !(lvl_s > priority_level_field) && !cmd_return_to_process_op && !cmd_return_from_gate_op)
      |=> (st_r == ST_IDLE))
      else $error("masked interrupt was taken");
endmodule // ies_intr_seq

// ==== ies_pkg.sv ====
package ies_pkg;
   ////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [7:0] REG_PSW = 8'h00;
   localparam logic [7:0] REG_PC = 8'h04;
   localparam logic [7:0] REG_SP = 8'h08;
   localparam logic [7:0] REG_PROCESS_BLOCK_POINTER = 8'h0c;
   localparam logic [7:0] REG_ISP = 8'h10;
   localparam logic [7:0] REG_TEMP = 8'h14;
   localparam logic [7:0] REG_STAT = 8'h18;
   localparam logic [7:0] REG_CMD = 8'h1c;
   localparam logic [7:0] REG_MAPW = 8'h20;
   ////////////////////////////////////////////////////////////////////////
   // status word layout
   localparam int ET_LSB = 0;
   localparam int TM_BIT = 2;
   localparam int ISC_LSB = 3;
   localparam int I_BIT = 7;
   localparam int R_BIT = 8;
   localparam int IPL_LSB = 13;
   localparam int QIE_BIT = 24;
   localparam logic [31:0] PSW_RESET = 32'h0001e03b;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   // exception classes, most severe first
   localparam logic [1:0] ET_RESET = 2'h0;
   localparam logic [1:0] ET_PROC = 2'h1;
   localparam logic [1:0] ET_STACK = 2'h2;
   localparam logic [1:0] ET_NORMAL = 2'h3;
   localparam logic [3:0] ISC_RUN = 4'h7;
   localparam logic [3:0] ISC_SAVED = 4'h0;
   localparam logic [1:0] ET_SAVED = 2'h1;
   localparam logic [3:0] ISC_OLD_PCB = 4'h0;
   localparam logic [3:0] ISC_NEW_PCB = 4'h1;
   localparam logic [3:0] ISC_INT_STACK = 4'h1;
   localparam logic [3:0] ISC_ID_FETCH = 4'h3;
   localparam logic [3:0] ISC_EXT_MEM = 4'h5;
   localparam logic [3:0] ISC_GATE_VEC = 4'h6;
   localparam logic [3:0] IPL_ALL = 4'hf;
   ////////////////////////////////////////////////////////////////////////
   // vector tables and control-block layout
   localparam logic [31:0] FULL_BASE = 32'h0000008c;
   localparam logic [31:0] QUICK_BASE = 32'h0000048c;
   localparam logic [1:0] FULL_SHIFT = 2'h2;
   localparam logic [1:0] QUICK_SHIFT = 2'h3;
   localparam logic [31:0] WORD = 32'h00000004;
   localparam logic [31:0] PAIR = 32'h00000008;
   localparam logic [31:0] SAVE_AREA_OFS = 32'h0000000c;
   localparam logic [31:0] MAP_OFS = 32'h00000018;

   typedef enum logic [10:0] {
      ST_IDLE = 11'h001, ST_IDF = 11'h002, ST_IDX = 11'h004,
      ST_PUSH = 11'h008, ST_SAVE = 11'h010, ST_LOAD = 11'h020,
      ST_MAP = 11'h040, ST_QPUSH = 11'h080, ST_QVEC = 11'h100,
      ST_RPOP = 11'h200, ST_RGPOP = 11'h400
   } ies_state_t;

   function automatic logic [31:0] ies_vec_addr(logic [31:0] base,
         logic [7:0] id, logic [1:0] sh);
      return base + ({24'h0, id} << sh);
   endfunction

   function automatic logic [31:0] ies_psw_mark(logic [31:0] processor_status_word,
         logic [3:0] internal_state_code, logic tm, logic [1:0] et);
      logic [31:0] p;
      p = processor_status_word;
      p[ISC_LSB +: 4] = internal_state_code;
      p[TM_BIT] = tm;
      p[ET_LSB +: 2] = et;
      return p;
   endfunction
endpackage

// ==== ies_mem_if.sv ====
`timescale 1ns/1ps
interface ies_mem_if;
   logic start;
   logic we;
   logic iack;
   logic kernel;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic done;
   logic fault;
   modport seq (output start, we, iack, kernel, addr, wdata,
      input rdata, done, fault);
   modport port (input start, we, iack, kernel, addr, wdata,
      output rdata, done, fault);
endinterface

// ==== ies_sync2.sv ====
`timescale 1ns/1ps
module ies_sync2 #(parameter int W = 5) (
   input logic pclk,
   input logic presetn,
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // ies_sync2

// ==== ies_mem_port.sv ====
`timescale 1ns/1ps
module ies_mem_port
   import ies_pkg::*;
(
   input logic pclk,
   input logic presetn,
   ies_mem_if.port mi,
   output logic mem_req,
   output logic mem_we,
   output logic mem_iack,
   output logic mem_kernel,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input logic mem_ack,
   input logic [31:0] mem_rdata,
   input logic mem_fault
);
   wire issue = mi.start && !mem_req;
   wire finish = mem_req && mem_ack;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_iack <= 1'b0;
         mem_kernel <= 1'b0;
         mem_addr <= ADDR_RESET;
         mem_wdata <= ADDR_RESET;
         mi.done <= 1'b0;
         mi.fault <= 1'b0;
         mi.rdata <= ADDR_RESET;
      end else begin
         mem_kernel <= mi.kernel;
         mi.done <= finish;
         if (issue) begin
            mem_req <= 1'b1;
            mem_we <= mi.we;
            mem_iack <= mi.iack;
            mem_addr <= mi.addr;
            mem_wdata <= mi.wdata;
         end else if (finish) begin
            mem_req <= 1'b0;
         end
         if (finish) begin
            // fault rides with the acknowledge of the access it belongs to
            mi.fault <= mem_fault;
            mi.rdata <= mem_rdata;
         end
      end
   end
endmodule // ies_mem_port

// ==== ies_mem_model.sv ====
`timescale 1ns/1ps
module ies_mem_model (
   input logic pclk,
   input logic mem_req,
   input logic mem_we,
   input logic mem_kernel,
   input logic mem_iack,
   input logic [31:0] mem_addr,
   input logic [31:0] mem_wdata,
   input logic [31:0] fault_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   output logic mem_fault
);
   logic [31:0] mem [logic [31:0]];
   // per address: {interrupt acknowledge, forced kernel} of the last access
   logic [1:0] kern [logic [31:0]];
   logic gap = 1'b0;
   logic slow = 1'b0;
   int cnt = 0;
   initial mem_ack = 1'b0;
   initial mem_fault = 1'b0;
   initial mem_rdata = 32'h0;
   ////////////////////////////////////////////////////////////////////////
   // answers alternate prompt and slow; idle read data keeps toggling
   always @(posedge pclk) begin
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!mem_req) gap <= 1'b0;
      else if (!gap && cnt > 0) cnt <= cnt - 1;
      else if (!gap) begin
         gap <= 1'b1;
         mem_ack <= 1'b1;
         mem_fault <= (mem_addr == fault_addr);
         kern[mem_addr] = {mem_iack, mem_kernel};
         if (mem_we) mem[mem_addr] = mem_wdata;
         else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'hdeadbeef;
         cnt <= slow ? 3 : 0;
         slow <= ~slow;
      end
   end
endmodule // ies_mem_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import ies_pkg::*;
   logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
   logic int_nmi = '0, pready, pslverr, mem_req, mem_we, mem_iack, e_r;
   logic mem_kernel, mem_ack, mem_fault;
   logic [7:0] paddr = '0;
   logic [3:0] int_level = '0;
   logic [31:0] pwdata = '0, fault_addr = 32'hfffffff0, q_r;
   logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
   int bad_count = 0, cmp_count = 0, cyc = 0;
   ies_intr_seq ies_intr_seq_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .int_nmi, .int_level,
      .mem_req, .mem_we, .mem_iack, .mem_kernel, .mem_addr, .mem_wdata,
      .mem_ack, .mem_rdata, .mem_fault);
   ies_mem_model ies_mem_model_i (.pclk, .mem_req, .mem_we, .mem_kernel,
      .mem_iack, .mem_addr, .mem_wdata, .fault_addr, .mem_ack,
      .mem_rdata, .mem_fault);
   always #10 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // generous ceiling, the whole run needs well under 2000 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q_r = prdata;
      e_r = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q_r, exp);
   endtask
   task wait_idle;
      repeat (8) @(posedge pclk);
      do apb(1'b0, REG_STAT, 32'h0); while (q_r[0] !== 1'b0);
   endtask
   task put(input logic [31:0] a, input logic [31:0] d);
      ies_mem_model_i.mem[a] = d;
   endtask
   function automatic logic [31:0] get(input logic [31:0] a);
      return ies_mem_model_i.mem[a];
   endfunction
   function automatic logic [31:0] kb(input logic [31:0] a);
      return {30'h0, ies_mem_model_i.kern[a]};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(REG_PSW, PSW_RESET);
      rd(8'h24, 32'h0);
      chk({31'h0, e_r}, 32'h1);
      put(32'h4, 32'h3);
      put(32'h98, 32'h400);
      put(32'h400, 32'ha080);
      put(32'h404, 32'h3000);
      wr(REG_PSW, 32'h403b);
      wr(REG_PROCESS_BLOCK_POINTER, 32'h200);
      wr(REG_ISP, 32'h300);
      wr(REG_PC, 32'h1000);
      wr(REG_SP, 32'h600);
      int_level <= 4'h4;
      wait_idle;
      rd(REG_TEMP, 32'h98);
      chk(get(32'h300), 32'h200);
      chk(get(32'h200), 32'h4001);
      chk(get(32'h204), 32'h1000);
      chk(kb(32'h98), 32'h1);
      chk(kb(32'h4), 32'h2);
      rd(REG_PROCESS_BLOCK_POINTER, 32'h40c);
      rd(REG_PC, 32'h3000);
      rd(REG_PSW, 32'ha03b);
      rd(REG_ISP, 32'h304);
      int_level <= 4'h0;
      wr(REG_CMD, 32'h1);
      wait_idle;
      rd(REG_PROCESS_BLOCK_POINTER, 32'h200);
      rd(REG_ISP, 32'h300);
      rd(REG_PSW, 32'h4001);
      chk({31'h0, ies_mem_model_i.mem.exists(32'h40c)}, 32'h0);
      put(32'h4a4, 32'h00800000);
      put(32'h4a8, 32'h2000);
      wr(REG_PSW, 32'h0100003b);
      wr(REG_PC, 32'h1000);
      int_level <= 4'h4;
      wait_idle;
      rd(REG_TEMP, 32'h4a4);
      chk(get(32'h600), 32'h0100003b);
      chk(get(32'h604), 32'h1000);
      chk(kb(32'h600), 32'h0);
      chk(kb(32'h4a4), 32'h1);
      rd(REG_SP, 32'h608);
      rd(REG_PSW, 32'h0081e03b);
      rd(REG_PC, 32'h2000);
      int_level <= 4'h0;
      wr(REG_CMD, 32'h2);
      wait_idle;
      rd(REG_PSW, 32'h0100003b);
      rd(REG_PC, 32'h1000);
      rd(REG_SP, 32'h600);
      fault_addr <= 32'h4;
      wr(REG_PSW, 32'h3b);
      int_level <= 4'h4;
      wait_idle;
      chk(q_r & 32'hf32, 32'h322);
      // clearing lets the still pending level in again, now faulting the push
      wr(REG_STAT, 32'h2);
      fault_addr <= 32'h300;
      wait_idle;
      chk(q_r & 32'hf32, 32'h102);
      int_level <= 4'h0;
      fault_addr <= 32'hfffffff0;
      wr(REG_STAT, 32'h2);
      apb(1'b0, REG_STAT, 32'h0);
      chk(q_r & 32'h3, 32'h0);
      // nonmaskable entry at priority 15; acknowledge data is not 0 here
      wr(REG_PSW, PSW_RESET);
      int_nmi <= 1'b1;
      wait_idle;
      rd(REG_TEMP, 32'h8c);
      end_of_test;
   end
endmodule // testbench
